// file: design/drds_pkg.sv
// Purpose: constants and carriers for the read-data sequencer
// Assumes: 10 MHz controller clock
// Notes: status bit positions follow the result-phase layout
package drds_pkg;
  localparam int CMD_BYTES = 9;
  localparam int CLK_MHZ = 10;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int OVR_FM_US = 27;
  localparam int OVR_MFM_US = 13;
  localparam logic [8:0] OVR_FM_CYC = 9'(OVR_FM_US * CLK_MHZ);
  localparam logic [8:0] OVR_MFM_CYC = 9'(OVR_MFM_US * CLK_MHZ);
  localparam logic [7:0] HLT_STEP_MS = 8'h02;
  localparam logic [7:0] HUT_STEP_MS = 8'h10;
  // command byte indices
  localparam int CB_OPC = 0;
  localparam int CB_SEL = 1;
  localparam int CB_CYL = 2;
  localparam int CB_HEAD = 3;
  localparam int CB_SECT = 4;
  localparam int CB_SIZE = 5;
  localparam int CB_LAST = 6;
  localparam int CB_DTL = 8;
  // command field positions
  localparam int OPC_TWO_SIDE = 7;
  localparam int OPC_DENSITY = 6;
  localparam int OPC_BYPASS = 5;
  localparam int SEL_HEAD = 2;
  // status field positions and values
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam int ST1_EN = 7;
  localparam int ST1_DE = 5;
  localparam int ST1_OR = 4;
  localparam int ST1_ND = 2;
  localparam int ST2_CM = 6;
  localparam int ST2_DD = 5;
  // sectors per side by size code class
  localparam logic [7:0] MAXSEC_SMALL = 8'h1A;
  localparam logic [7:0] MAXSEC_MID = 8'h0F;
  localparam logic [7:0] MAXSEC_BIG = 8'h08;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;

  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } drds_id_t;

  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    drds_id_t id;
  } drds_result_t;
endpackage

// file: design/drds_sequencer.sv
// Purpose: execution logic of the read-data command of a floppy controller
// Assumes: disk read path delivers decoded id fields, marks, bytes and crc results
// Notes: one command at a time; result held until result_ack
`timescale 1ns/10ps
module drds_sequencer #(
  parameter int TICK_CYCLES = drds_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_byte_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic dma_mode,
  input wire logic [6:0] head_load_code,
  input wire logic [3:0] head_unload_code,
  input wire logic host_read,
  input wire logic terminal_count,
  input wire logic result_ack,
  input wire logic index_pulse,
  input wire logic id_valid,
  input wire drds_pkg::drds_id_t id_in,
  input wire logic id_crc_ok,
  input wire logic data_mark_valid,
  input wire logic data_mark_deleted,
  input wire logic disk_byte_valid,
  input wire logic [7:0] disk_byte,
  input wire logic data_end,
  input wire logic data_crc_ok,
  output logic head_load_r,
  output logic density_select_r,
  output logic [7:0] host_data_r,
  output logic dma_request_r,
  output logic host_interrupt_r,
  output logic host_request_bit_r,
  output logic transfer_direction_bit_r,
  output logic result_valid_r,
  output drds_pkg::drds_result_t result_r
);
  import drds_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_CMD, S_SETTLE, S_SEARCH, S_MARK, S_DATA, S_SKIP, S_RESULT} drds_state_t;

  drds_state_t state_r;
  logic [7:0] cmd_mem [CMD_BYTES];
  logic [3:0] cmd_cnt_r;
  drds_id_t cur_r;
  logic [7:0] st1_r;
  logic [7:0] st2_r;
  logic [1:0] ic_r;
  logic tc_seen_r;
  logic idx_seen_r;
  logic deleted_r;
  logic [12:0] byte_cnt_r;
  logic pend_r;
  logic [8:0] ovr_cnt_r;
  logic [13:0] tick_cnt_r;
  logic tick;
  logic [7:0] ms_cnt_r;
  logic settle_done;
  logic unload_done;
  logic pass_byte;
  logic overrun;
  logic last_hit;
  logic side_flip;
  logic [7:0] eff_last;
  logic two_side;
  logic bypass;

  // sector cap per side from density and size code
  function automatic logic [7:0] max_sectors(input logic dens, input logic [7:0] n);
    logic [7:0] cls;
    cls = dens ? n - 8'h01 : n;
    case (cls)
      8'h00: max_sectors = MAXSEC_SMALL;
      8'h01: max_sectors = MAXSEC_MID;
      default: max_sectors = MAXSEC_BIG;
    endcase
  endfunction

  assign two_side = cmd_mem[CB_OPC][OPC_TWO_SIDE];
  assign bypass = cmd_mem[CB_OPC][OPC_BYPASS];
  always_comb begin
    eff_last = max_sectors(density_select_r, cur_r.size);
    if (cmd_mem[CB_LAST] < eff_last) begin
      eff_last = cmd_mem[CB_LAST];
    end
  end
  assign last_hit = (cur_r.sector == eff_last);
  assign side_flip = last_hit && two_side && !cur_r.head[0];

  // bytes past the short length stay off the bus when size code is zero
  assign pass_byte = (state_r == S_DATA) && disk_byte_valid && !tc_seen_r && !terminal_count
    && ((cur_r.size != 8'h00) || (byte_cnt_r < {5'h00, cmd_mem[CB_DTL]}));
  assign overrun = pend_r && ((ovr_cnt_r == 9'h000) || pass_byte);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_cnt_r <= 4'h0;
      for (int i = 0; i < CMD_BYTES; i++) begin
        cmd_mem[i] <= 8'h00;
      end
    end else if (state_r == S_IDLE || state_r == S_CMD) begin
      if (cmd_byte_valid) begin
        cmd_mem[cmd_cnt_r] <= cmd_byte;
        cmd_cnt_r <= (cmd_cnt_r == 4'(CMD_BYTES - 1)) ? 4'h0 : cmd_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      density_select_r <= 1'b0;
    end else if (state_r == S_CMD && cmd_byte_valid && cmd_cnt_r == 4'(CMD_BYTES - 1)) begin
      density_select_r <= cmd_mem[CB_OPC][OPC_DENSITY];
    end
  end

  // millisecond enable, free running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_r <= 14'h0000;
    end else begin
      tick_cnt_r <= tick ? 14'h0000 : tick_cnt_r + 14'h0001;
    end
  end
  assign tick = (tick_cnt_r == 14'(TICK_CYCLES - 1));

  // one ms counter serves both settle and unload; they never overlap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ms_cnt_r <= 8'h00;
    end else if (state_r == S_SETTLE || (state_r == S_IDLE && head_load_r)) begin
      if (tick) begin
        ms_cnt_r <= ms_cnt_r + 8'h01;
      end
    end else begin
      ms_cnt_r <= 8'h00;
    end
  end
  assign settle_done = (ms_cnt_r >= 8'({head_load_code, 1'b0}));
  assign unload_done = ({4'h0, ms_cnt_r} >= 12'(head_unload_code) * {4'h0, HUT_STEP_MS});

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      head_load_r <= 1'b0;
    end else if (state_r == S_SETTLE) begin
      head_load_r <= 1'b1;
    end else if (state_r == S_IDLE && head_load_r && unload_done && !cmd_byte_valid) begin
      head_load_r <= 1'b0;
    end
  end

  // host byte path
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_data_r <= 8'h00;
      pend_r <= 1'b0;
      dma_request_r <= 1'b0;
      host_interrupt_r <= 1'b0;
    end else if (pass_byte) begin
      host_data_r <= disk_byte;
      pend_r <= 1'b1;
      dma_request_r <= dma_mode;
      host_interrupt_r <= !dma_mode;
    end else if (host_read || state_r == S_RESULT) begin
      pend_r <= 1'b0;
      dma_request_r <= 1'b0;
      host_interrupt_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovr_cnt_r <= 9'h000;
    end else if (pass_byte) begin
      ovr_cnt_r <= density_select_r ? OVR_MFM_CYC : OVR_FM_CYC;
    end else if (pend_r && ovr_cnt_r != 9'h000) begin
      ovr_cnt_r <= ovr_cnt_r - 9'h001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_request_bit_r <= 1'b1;
      transfer_direction_bit_r <= 1'b0;
    end else begin
      host_request_bit_r <= (state_r == S_IDLE) || (state_r == S_CMD && !(cmd_byte_valid && cmd_cnt_r == 4'h8))
        || (state_r == S_RESULT) || pass_byte || (pend_r && !host_read);
      transfer_direction_bit_r <= !(state_r == S_IDLE)
        && !(state_r == S_CMD && !(cmd_byte_valid && cmd_cnt_r == 4'h8));
    end
  end

  // sequencing, target id and status
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
      cur_r <= '0;
      st1_r <= 8'h00;
      st2_r <= 8'h00;
      ic_r <= IC_NORMAL;
      tc_seen_r <= 1'b0;
      idx_seen_r <= 1'b0;
      deleted_r <= 1'b0;
      byte_cnt_r <= 13'h0000;
      result_valid_r <= 1'b0;
    end else begin
      if (terminal_count && state_r != S_IDLE && state_r != S_CMD && state_r != S_RESULT) begin
        tc_seen_r <= 1'b1;
      end
      case (state_r)
        S_IDLE: state_r <= cmd_byte_valid ? S_CMD : S_IDLE;
        S_CMD: begin
          if (cmd_byte_valid && cmd_cnt_r == 4'(CMD_BYTES - 1)) begin
            cur_r <= {cmd_mem[CB_CYL], cmd_mem[CB_HEAD], cmd_mem[CB_SECT], cmd_mem[CB_SIZE]};
            st1_r <= 8'h00;
            st2_r <= 8'h00;
            ic_r <= IC_NORMAL;
            tc_seen_r <= 1'b0;
            idx_seen_r <= 1'b0;
            state_r <= head_load_r ? S_SEARCH : S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (settle_done) begin
            state_r <= S_SEARCH;
          end
        end
        S_SEARCH: begin
          if (tc_seen_r) begin
            state_r <= S_RESULT;
            result_valid_r <= 1'b1;
          end else if (id_valid && id_in.sector == cur_r.sector) begin
            idx_seen_r <= 1'b0;
            if (!id_crc_ok) begin
              st1_r[ST1_DE] <= 1'b1;
              ic_r <= IC_ABNORMAL;
              state_r <= S_RESULT;
              result_valid_r <= 1'b1;
            end else begin
              state_r <= S_MARK;
            end
          end else if (index_pulse) begin
            idx_seen_r <= 1'b1;
            if (idx_seen_r) begin
              st1_r[ST1_ND] <= 1'b1;
              ic_r <= IC_ABNORMAL;
              state_r <= S_RESULT;
              result_valid_r <= 1'b1;
            end
          end
        end
        S_MARK: begin
          if (data_mark_valid) begin
            byte_cnt_r <= 13'h0000;
            deleted_r <= data_mark_deleted;
            state_r <= (data_mark_deleted && bypass) ? S_SKIP : S_DATA;
          end
        end
        S_DATA, S_SKIP: begin
          if (disk_byte_valid && byte_cnt_r != 13'h1FFF) begin
            byte_cnt_r <= byte_cnt_r + 13'h0001;
          end
          if (overrun) begin
            st1_r[ST1_OR] <= 1'b1;
            ic_r <= IC_ABNORMAL;
            state_r <= S_RESULT;
            result_valid_r <= 1'b1;
          end else if (data_end) begin
            if (!data_crc_ok) begin
              st1_r[ST1_DE] <= 1'b1;
              st2_r[ST2_DD] <= 1'b1;
              ic_r <= IC_ABNORMAL;
              state_r <= S_RESULT;
              result_valid_r <= 1'b1;
            end else if (deleted_r && state_r == S_DATA) begin
              st2_r[ST2_CM] <= 1'b1;
              ic_r <= IC_ABNORMAL;
              state_r <= S_RESULT;
              result_valid_r <= 1'b1;
            end else begin
              // advance the target id past the finished sector
              cur_r.sector <= last_hit ? FIRST_SECTOR : cur_r.sector + 8'h01;
              if (last_hit && two_side) begin
                cur_r.head[0] <= !cur_r.head[0];
              end
              if (last_hit && !side_flip) begin
                cur_r.cyl <= cur_r.cyl + 8'h01;
              end
              if (tc_seen_r || terminal_count) begin
                state_r <= S_RESULT;
                result_valid_r <= 1'b1;
              end else if (last_hit && !side_flip) begin
                st1_r[ST1_EN] <= 1'b1;
                ic_r <= IC_ABNORMAL;
                state_r <= S_RESULT;
                result_valid_r <= 1'b1;
              end else begin
                state_r <= S_SEARCH;
              end
            end
          end
        end
        S_RESULT: begin
          if (result_ack) begin
            result_valid_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // result fields are the live target id and status flops
  assign result_r.st0 = {ic_r, 3'h0, cur_r.head[0], cmd_mem[CB_SEL][1:0]};
  assign result_r.st1 = st1_r;
  assign result_r.st2 = st2_r;
  assign result_r.id = cur_r;
endmodule

// file: sim/drds_host_model.sv
// Purpose: host that answers each byte request of the sequencer
// Assumes: host signals change on the falling edge
// Notes: delay above the service limit provokes an overrun
`timescale 1ns/10ps
module drds_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic dma_request_r,
  input wire logic host_interrupt_r,
  input wire logic [7:0] host_data_r,
  input wire logic [8:0] delay,
  output logic host_read,
  output int nbytes,
  output logic [7:0] sum
);
  initial begin
    host_read = 1'b0;
    nbytes = 0;
    sum = 8'h00;
    forever begin
      @(negedge clk);
      if (!reset && (dma_request_r || host_interrupt_r)) begin
        repeat (delay) @(negedge clk);
        // request may have been withdrawn while a slow host waited
        if (dma_request_r || host_interrupt_r) begin
          sum = sum + host_data_r;
          nbytes++;
          host_read = 1'b1;
          @(negedge clk);
          host_read = 1'b0;
        end
      end
    end
  end
endmodule

// file: sim/drds_sequencer_sva.sv
// Purpose: port-level checks of the read-data sequencer
// Assumes: one clock, reset asynchronous active high
// Notes: bound into every sequencer instance
`timescale 1ns/10ps
module drds_sequencer_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic dma_mode,
  input wire logic host_read,
  input wire logic disk_byte_valid,
  input wire logic [7:0] disk_byte,
  input wire logic result_ack,
  input wire logic head_load_r,
  input wire logic [7:0] host_data_r,
  input wire logic dma_request_r,
  input wire logic host_interrupt_r,
  input wire logic result_valid_r,
  input wire drds_pkg::drds_result_t result_r
);
  import drds_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_up;
    $rose(dma_request_r || host_interrupt_r);
  endsequence
  sequence s_taken;
    (dma_request_r || host_interrupt_r) && host_read && !disk_byte_valid;
  endsequence
  a_byte_cause: assert property (s_up |-> $past(disk_byte_valid))
    else $error("request without disk byte");
  a_byte_data: assert property (s_up |-> host_data_r == $past(disk_byte))
    else $error("presented byte differs from disk byte");
  a_req_mode: assert property (s_up |-> dma_request_r == $past(dma_mode) && host_interrupt_r == !$past(dma_mode))
    else $error("request kind does not follow mode");
  a_req_clear: assert property (s_taken |=> !(dma_request_r || host_interrupt_r))
    else $error("request kept after host read");
  a_head_loaded: assert property ((dma_request_r || host_interrupt_r) |-> head_load_r)
    else $error("byte offered with head unloaded");
  a_result_stable: assert property (result_valid_r && !result_ack |=> result_valid_r && $stable(result_r))
    else $error("result changed before ack");
  a_abn_code: assert property (result_valid_r && (result_r.st1[ST1_ND] || result_r.st1[ST1_DE] ||
    result_r.st1[ST1_OR]) |-> result_r.st0[7:6] == IC_ABNORMAL)
    else $error("error flag without abnormal code");
  a_dd_implies: assert property (result_valid_r && result_r.st2[ST2_DD] |-> result_r.st1[ST1_DE])
    else $error("data crc flag without crc error");
endmodule
bind drds_sequencer drds_sequencer_sva i_sva (.clk(clk), .reset(reset), .dma_mode(dma_mode),
  .host_read(host_read), .disk_byte_valid(disk_byte_valid), .disk_byte(disk_byte), .result_ack(result_ack),
  .head_load_r(head_load_r), .host_data_r(host_data_r), .dma_request_r(dma_request_r),
  .host_interrupt_r(host_interrupt_r), .result_valid_r(result_valid_r), .result_r(result_r));

// file: sim/drds_sequencer_test.sv
// Purpose: self-checking bench for the read-data sequencer
// Assumes: stimulus on the falling edge, fixed random seed
// Notes: tick shortened to 10 cycles so settle and unload stay short
`timescale 1ns/10ps
module drds_sequencer_test;
  import drds_pkg::*;
  logic clk = 1'b0, reset = 1'b1, cmd_byte_valid = 1'b0, dma_mode = 1'b1, terminal_count = 1'b0;
  logic result_ack = 1'b0, index_pulse = 1'b0, id_valid = 1'b0, id_crc_ok = 1'b1, data_mark_valid = 1'b0;
  logic data_mark_deleted = 1'b0, disk_byte_valid = 1'b0, data_end = 1'b0, data_crc_ok = 1'b1;
  logic host_read, head_load_r, density_select_r, dma_request_r, host_interrupt_r;
  logic host_request_bit_r, transfer_direction_bit_r, result_valid_r, mt, sk, density_select;
  logic [6:0] load_code = 7'h01;
  logic [3:0] unload_code = 4'h1;
  logic [7:0] cmd_byte = 8'h00, disk_byte = 8'h00, host_data_r, sum, exp_sum, cyl, hd, nsz, short_sector_length;
  logic [8:0] delay = 9'h000;
  drds_id_t id_in = '0, exp_id;
  drds_result_t result_r;
  int seed = 4840, err_total = 0, checks_done = 0, cyc = 0, nbytes, exp_cnt;
  always #50 clk = ~clk;
  drds_sequencer #(.TICK_CYCLES(10)) i_dut (.clk(clk), .reset(reset), .cmd_byte_valid(cmd_byte_valid),
    .cmd_byte(cmd_byte), .dma_mode(dma_mode), .head_load_code(load_code), .head_unload_code(unload_code),
    .host_read(host_read), .terminal_count(terminal_count), .result_ack(result_ack), .index_pulse(index_pulse),
    .id_valid(id_valid), .id_in(id_in), .id_crc_ok(id_crc_ok), .data_mark_valid(data_mark_valid),
    .data_mark_deleted(data_mark_deleted), .disk_byte_valid(disk_byte_valid), .disk_byte(disk_byte),
    .data_end(data_end), .data_crc_ok(data_crc_ok), .head_load_r(head_load_r),
    .density_select_r(density_select_r), .host_data_r(host_data_r), .dma_request_r(dma_request_r),
    .host_interrupt_r(host_interrupt_r), .host_request_bit_r(host_request_bit_r),
    .transfer_direction_bit_r(transfer_direction_bit_r), .result_valid_r(result_valid_r), .result_r(result_r));
  drds_host_model i_host (.clk(clk), .reset(reset), .dma_request_r(dma_request_r),
    .host_interrupt_r(host_interrupt_r), .host_data_r(host_data_r), .delay(delay), .host_read(host_read),
    .nbytes(nbytes), .sum(sum));
  task automatic end_sim();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  function automatic bit passes(input int i, input int tc_at, input bit del);
    return i < tc_at && (nsz != 8'h00 || i < int'(short_sector_length)) && !(del && sk);
  endfunction
  task automatic start(input logic [7:0] r, input logic [7:0] last_sector_number);
    logic [7:0] b [9];
    dma_mode = 1'($random(seed));
    // low opcode bits are not decoded by this block, any value will do
    b = '{{mt, density_select, sk, 5'h06}, {5'h00, hd[0], 2'h0}, cyl, hd, r, nsz, last_sector_number, 8'h1B, short_sector_length};
    for (int i = 0; i < CMD_BYTES; i++) begin
      chk({6'h00, host_request_bit_r, transfer_direction_bit_r}, 8'h02, "poll");
      cmd_byte = b[i];
      cmd_byte_valid = 1'b1;
      tick(1);
    end
    cmd_byte_valid = 1'b0;
    exp_cnt = nbytes;
    exp_sum = sum;
    tick(1);
    chk({7'h00, transfer_direction_bit_r}, 8'h01, "exec dir");
    chk({7'h00, density_select_r}, {7'h00, density_select}, "density");
    tick(30);
    chk({7'h00, head_load_r}, 8'h01, "head");
  endtask
  task automatic sector(input logic [7:0] r, input bit del, input int nb, input int tc_at, input bit crc);
    tick(4);
    id_in = '{cyl, hd, r, nsz};
    pulse(id_valid);
    tick(4);
    data_mark_deleted = del;
    pulse(data_mark_valid);
    for (int i = 0; i < nb; i++) begin
      tick(3);
      if (i == tc_at) terminal_count = 1'b1;
      tick(3);
      disk_byte = 8'($random(seed));
      if (passes(i, tc_at, del)) begin
        exp_cnt++;
        exp_sum += disk_byte;
      end
      pulse(disk_byte_valid);
    end
    tick(4);
    data_crc_ok = crc;
    pulse(data_end);
    data_crc_ok = 1'b1;
  endtask
  // mode 0 status only, 1 adds byte count, 2 adds result id
  task automatic result(input logic [7:0] s1, input logic [7:0] s2, input int mode);
    int k = 0;
    while (result_valid_r !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    terminal_count = 1'b0;
    chk({7'h00, result_valid_r}, 8'h01, "result");
    if (s1 != 8'h00 || mode == 2) begin
      chk({6'h00, result_r.st0[7:6]}, {6'h00, (s1 != 8'h00) ? IC_ABNORMAL : IC_NORMAL}, "ic");
    end
    chk(result_r.st1, s1, "st1");
    chk(result_r.st2, s2, "st2");
    if (mode > 0) begin
      chk(8'(nbytes), 8'(exp_cnt), "bytes");
      chk(sum, exp_sum, "sum");
    end
    for (int b = 0; b < 4 && mode == 2; b++) begin
      chk(result_r.id[b*8 +: 8], exp_id[b*8 +: 8], "id");
    end
    pulse(result_ack);
    tick(4);
  endtask
  initial begin
    {mt, sk, density_select} = 3'h0;
    {cyl, hd, nsz, short_sector_length} = {8'h05, 8'h00, 8'h00, 8'h04};
    tick(12);
    reset = 1'b0;
    tick(1);
    chk({6'h00, host_request_bit_r, result_valid_r}, 8'h02, "reset");
    density_select = 1'($random(seed));
    start(8'h03, 8'h08);
    sector(8'h03, 1'b0, 6, 99, 1'b1);
    sector(8'h04, 1'b0, 6, 2, 1'b1);
    exp_id = '{cyl, hd, 8'h05, nsz};
    result(8'h00, 8'h00, 2);
    density_select = 1'b0;
    start(8'h03, 8'h08);
    id_in = '{cyl, hd, 8'h07, nsz};
    pulse(id_valid);
    for (int i = 0; i < 2; i++) begin
      tick(20);
      pulse(index_pulse);
    end
    result(8'h01 << ST1_ND, 8'h00, 1);
    start(8'h03, 8'h08);
    sector(8'h03, 1'b0, 3, 99, 1'b0);
    result(8'h01 << ST1_DE, 8'h01 << ST2_DD, 1);
    start(8'h03, 8'h08);
    sector(8'h03, 1'b1, 3, 99, 1'b1);
    result(8'h00, 8'h01 << ST2_CM, 1);
    sk = 1'b1;
    start(8'h03, 8'h08);
    sector(8'h03, 1'b1, 3, 99, 1'b1);
    sector(8'h04, 1'b0, 3, 1, 1'b1);
    result(8'h00, 8'h00, 2);
    sk = 1'b0;
    delay = 9'd300;
    start(8'h03, 8'h08);
    sector(8'h03, 1'b0, 3, 99, 1'b1);
    result(8'h01 << ST1_OR, 8'h00, 0);
    delay = 9'h000;
    tick(300);
    short_sector_length = 8'hFF;
    for (int j = 0; j < 3; j++) begin
      mt = (j == 1);
      nsz = (j == 2) ? 8'h02 : 8'h01;
      start(8'h08, (j == 2) ? 8'h0A : 8'h08);
      sector(8'h08, 1'b0, 3, 2, 1'b1);
      exp_id = mt ? drds_id_t'{cyl, hd ^ 8'h01, FIRST_SECTOR, nsz} : drds_id_t'{cyl + 8'h01, hd, FIRST_SECTOR, nsz};
      result(8'h00, 8'h00, 2);
    end
    tick(100);
    chk({7'h00, head_load_r}, 8'h01, "head held");
    tick(150);
    chk({7'h00, head_load_r}, 8'h00, "head dropped");
    end_sim();
  end
endmodule
